// *** rtl/scar_pkg.sv ***
// package of constants and state type for the stats counter access registers
package scar_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [9:0] ADDR_TX_CLOCK_OFF_STATUS      = 10'h09C;
   localparam logic [9:0] ADDR_PLL_REF_CLOCK_OFF_STATUS = 10'h09D;
   localparam logic [9:0] ADDR_TRANSFER_COMMAND         = 10'h207;
   localparam logic [9:0] ADDR_COUNTER_BYTE_HIGH        = 10'h214;
   localparam logic [9:0] ADDR_COUNTER_BYTE_MIDDLE      = 10'h215;
   localparam logic [9:0] ADDR_COUNTER_BYTE_LOW         = 10'h216;
   localparam logic [9:0] ADDR_COUNTER_TARGET_SELECT    = 10'h217;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] TX_OFF_RST   = 8'hFF;
   localparam logic [1:0] PLL_OFF_RST  = 2'h3;
   localparam logic [7:0] BYTE_REG_RST = 8'h00;

   // ****************************************************************
   // transfer command fields
   // ****************************************************************
   localparam int         CMD_DONE_BIT = 7;
   localparam int         CMD_IE_BIT   = 3;
   localparam int         CMD_DIR_BIT  = 2;
   localparam logic [1:0] CMD_VALUE    = 2'h1;
   localparam logic [1:0] CMD_IRQ_EN   = 2'h2;

   // ****************************************************************
   // selector fields and counter types
   // ****************************************************************
   localparam int         SEL_TYPE_LSB = 4;
   localparam logic [3:0] TYPE_RX_BAD_ICP = 4'h0;
   localparam logic [3:0] TYPE_RX_HEC     = 4'h1;
   localparam logic [3:0] TYPE_RX_IDLE    = 4'h2;
   localparam logic [3:0] TYPE_RX_TOTAL   = 4'h3;
   localparam logic [3:0] TYPE_TX_STUFF   = 4'h5;
   localparam logic [3:0] TYPE_TX_IDLE    = 4'h6;
   localparam logic [3:0] TYPE_TX_TOTAL   = 4'h7;
   localparam logic [3:0] TYPE_UT_HEC     = 4'h8;
   localparam logic [3:0] TYPE_UT_UNASGN  = 4'h9;
   localparam logic [3:0] TYPE_UT_IDLE    = 4'hA;
   localparam logic [3:0] TYPE_UT_ALL     = 4'hB;
   localparam logic [3:0] LINK_MAX        = 4'h7;
   localparam logic [3:0] GROUP_MIN       = 4'h8;
   localparam logic [3:0] GROUP_MAX       = 4'hB;

   localparam int CNT_W   = 24;
   localparam int CNT_NUM = 128;

   // ****************************************************************
   // state of the block
   // ****************************************************************
   typedef struct packed {
      logic [7:0]                    tx_off_m;
      logic [7:0]                    tx_off_s;
      logic [1:0]                    pll_off_m;
      logic [1:0]                    pll_off_s;
      logic [2:0]                    ctl_m;
      logic [2:0]                    ctl_s;
      logic                          wr_prev;
      logic [9:0]                    addr_m;
      logic [9:0]                    addr_s;
      logic [7:0]                    din_m;
      logic [7:0]                    din_s;
      logic [7:0]                    byte_high;
      logic [7:0]                    byte_middle;
      logic [7:0]                    byte_low;
      logic [7:0]                    select;
      logic [1:0]                    cmd_code;
      logic                          cmd_dir;
      logic                          cmd_ie;
      logic [2:0]                    cmd_rsvd;
      logic                          done;
      logic                          busy;
      logic [7:0]                    dout;
      logic                          doe;
      logic [CNT_NUM-1:0][CNT_W-1:0] cnt;
      logic [CNT_NUM-1:0]            ie;
   } scar_state_type;

   localparam scar_state_type SCAR_STATE_RST = '{
      tx_off_m    : TX_OFF_RST,
      tx_off_s    : TX_OFF_RST,
      pll_off_m   : PLL_OFF_RST,
      pll_off_s   : PLL_OFF_RST,
      byte_high   : BYTE_REG_RST,
      byte_middle : BYTE_REG_RST,
      byte_low    : BYTE_REG_RST,
      select      : BYTE_REG_RST,
      default     : '0
   };

endpackage

// *** rtl/scar_regs.sv ***
// register bank with indirect access to the cell statistics counters
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module scar_regs
   import scar_pkg::*;
(
   input  wire logic                        CLK_SYS,
   input  wire logic                        NRST,
   input  wire logic                        UP_CS_N,
   input  wire logic                        UP_RD_N,
   input  wire logic                        UP_WR_N,
   input  wire logic [9:0]                  UP_ADDR,
   input  wire logic [7:0]                  UP_DATA_IN,
   output      logic [7:0]                  UP_DATA_OUT,
   output      logic                        UP_DATA_OE,
   input  wire logic [7:0]                  TX_CLOCK_OFF,
   input  wire logic                        PLL_REFERENCE_ZERO_OFF,
   input  wire logic                        PLL_REFERENCE_ONE_OFF,
   input  wire logic [scar_pkg::CNT_NUM-1:0] CNT_EVENT,
   output      logic [scar_pkg::CNT_NUM-1:0] CNT_IRQ_ENABLE
);
   import scar_pkg::*;

   scar_state_type s_q;
   scar_state_type s_d;

   // ****************************************************************
   // counter slot helpers
   // ****************************************************************
   function automatic logic slot_valid(input logic [6:0] slot);
      logic [3:0] typ;
      typ = slot[6:3];
      unique case (typ)
         TYPE_RX_BAD_ICP, TYPE_RX_HEC, TYPE_RX_IDLE, TYPE_RX_TOTAL,
         TYPE_TX_STUFF, TYPE_TX_IDLE, TYPE_TX_TOTAL:
            slot_valid = 1'b1;
         TYPE_UT_HEC, TYPE_UT_UNASGN, TYPE_UT_IDLE, TYPE_UT_ALL:
            slot_valid = ~slot[2];
         default:
            slot_valid = 1'b0;
      endcase
   endfunction

   // selector decode: slot index and legality
   function automatic logic [7:0] sel_decode(input logic [7:0] sel);
      logic [3:0] typ;
      logic [3:0] lnk;
      logic       ok;
      typ = sel[7:SEL_TYPE_LSB];
      lnk = sel[SEL_TYPE_LSB-1:0];
      if (typ >= TYPE_UT_HEC && typ <= TYPE_UT_ALL) begin
         ok = (lnk >= GROUP_MIN) && (lnk <= GROUP_MAX);
      end else begin
         ok = (lnk <= LINK_MAX);
      end
      sel_decode = {ok & slot_valid({typ, lnk[2:0]}), typ, lnk[2:0]};
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [7:0] dec;
      logic [6:0] slot;
      logic       hit;
      logic       wr_go;
      logic       rd_act;
      dec    = sel_decode(s_q.select);
      slot   = dec[6:0];
      hit    = dec[7];
      wr_go  = 1'b0;
      rd_act = 1'b0;
      s_d    = s_q;

      s_d.tx_off_m  = TX_CLOCK_OFF;
      s_d.tx_off_s  = s_q.tx_off_m;
      s_d.pll_off_m = {PLL_REFERENCE_ONE_OFF, PLL_REFERENCE_ZERO_OFF};
      s_d.pll_off_s = s_q.pll_off_m;
      s_d.ctl_m     = {~UP_CS_N, ~UP_RD_N, ~UP_WR_N};
      s_d.ctl_s     = s_q.ctl_m;
      s_d.addr_m    = UP_ADDR;
      s_d.addr_s    = s_q.addr_m;
      s_d.din_m     = UP_DATA_IN;
      s_d.din_s     = s_q.din_m;

      wr_go     = s_q.ctl_s[2] & s_q.ctl_s[0] & ~s_q.wr_prev;
      rd_act    = s_q.ctl_s[2] & s_q.ctl_s[1];
      s_d.wr_prev = s_q.ctl_s[2] & s_q.ctl_s[0];

      // counting events from the cell paths
      for (int i = 0; i < CNT_NUM; i++) begin
         if (CNT_EVENT[i] && slot_valid(7'(i))) begin
            s_d.cnt[i] = s_q.cnt[i] + 24'h000001;
         end
      end

      // ****************************************************************
      // transfer execution, one cycle after the command write
      // ****************************************************************
      if (s_q.busy) begin
         s_d.busy = 1'b0;
         s_d.done = 1'b1;
         if (s_q.cmd_code == CMD_VALUE) begin
            if (s_q.cmd_dir) begin
               s_d.byte_high   = hit ? s_q.cnt[slot][23:16] : 8'h00;
               s_d.byte_middle = hit ? s_q.cnt[slot][15:8]  : 8'h00;
               s_d.byte_low    = hit ? s_q.cnt[slot][7:0]   : 8'h00;
            end else if (hit) begin
               s_d.cnt[slot] = {s_q.byte_high, s_q.byte_middle, s_q.byte_low};
            end
         end else if (s_q.cmd_code == CMD_IRQ_EN) begin
            if (s_q.cmd_dir) begin
               s_d.cmd_ie = hit & s_q.ie[slot];
            end else if (hit) begin
               s_d.ie[slot] = s_q.cmd_ie;
            end
         end
      end

      // ****************************************************************
      // host writes
      // ****************************************************************
      if (wr_go) begin
         unique case (s_q.addr_s)
            ADDR_COUNTER_BYTE_HIGH:     s_d.byte_high   = s_q.din_s;
            ADDR_COUNTER_BYTE_MIDDLE:   s_d.byte_middle = s_q.din_s;
            ADDR_COUNTER_BYTE_LOW:      s_d.byte_low    = s_q.din_s;
            ADDR_COUNTER_TARGET_SELECT: s_d.select      = s_q.din_s;
            ADDR_TRANSFER_COMMAND: begin
               s_d.cmd_code = s_q.din_s[1:0];
               s_d.cmd_dir  = s_q.din_s[CMD_DIR_BIT];
               s_d.cmd_ie   = s_q.din_s[CMD_IE_BIT];
               s_d.cmd_rsvd = s_q.din_s[6:4];
               if (!s_q.busy && (s_q.din_s[1:0] == CMD_VALUE ||
                                 s_q.din_s[1:0] == CMD_IRQ_EN)) begin
                  s_d.busy = 1'b1;
                  s_d.done = 1'b0;
               end else if (!s_q.busy && !s_q.din_s[CMD_DONE_BIT]) begin
                  s_d.done = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // ****************************************************************
      // host reads
      // ****************************************************************
      s_d.doe  = rd_act;
      s_d.dout = 8'h00;
      if (rd_act) begin
         unique case (s_q.addr_s)
            ADDR_TX_CLOCK_OFF_STATUS:      s_d.dout = s_q.tx_off_s;
            ADDR_PLL_REF_CLOCK_OFF_STATUS: s_d.dout = {6'h00, s_q.pll_off_s};
            ADDR_COUNTER_BYTE_HIGH:        s_d.dout = s_q.byte_high;
            ADDR_COUNTER_BYTE_MIDDLE:      s_d.dout = s_q.byte_middle;
            ADDR_COUNTER_BYTE_LOW:         s_d.dout = s_q.byte_low;
            ADDR_COUNTER_TARGET_SELECT:    s_d.dout = s_q.select;
            ADDR_TRANSFER_COMMAND:
               s_d.dout = {s_q.done, s_q.cmd_rsvd, s_q.cmd_ie, s_q.cmd_dir,
                           s_q.cmd_code};
            default:                       s_d.dout = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s_q <= SCAR_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign UP_DATA_OUT    = s_q.dout;
   assign UP_DATA_OE     = s_q.doe;
   assign CNT_IRQ_ENABLE = s_q.ie;

endmodule

// *** bench/scar_regs_monitor.sv ***
// assertion checker for the stats counter access register bank
`timescale 1ns/1ps
module scar_regs_monitor (
   input logic         CLK_SYS,
   input logic         NRST,
   input logic         UP_CS_N,
   input logic         UP_RD_N,
   input logic         UP_WR_N,
   input logic [9:0]   UP_ADDR,
   input logic [7:0]   UP_DATA_OUT,
   input logic         UP_DATA_OE,
   input logic [7:0]   TX_CLOCK_OFF,
   input logic         PLL_REFERENCE_ZERO_OFF,
   input logic         PLL_REFERENCE_ONE_OFF,
   input logic [127:0] CNT_IRQ_ENABLE
);
   logic rd_on;
   assign rd_on = !UP_CS_N && !UP_RD_N;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);
   // ****************************************************************
   // checks
   // ****************************************************************
   AST_OE_RISE: assert property ((rd_on && UP_ADDR == 10'h214)[*4] |-> UP_DATA_OE)
      else $error("read enable late");
   AST_OE_FALL: assert property ((!rd_on)[*4] |-> !UP_DATA_OE)
      else $error("read enable stuck");
   AST_OE_CAUSE: assert property ($rose(UP_DATA_OE) |-> $past(rd_on, 3))
      else $error("read enable without strobe");
   AST_DOUT_IDLE: assert property (!UP_DATA_OE |-> UP_DATA_OUT == 8'h00)
      else $error("data out while idle");
   AST_TX_STATUS: assert property ((rd_on && UP_ADDR == 10'h09C && $stable(TX_CLOCK_OFF))[*4]
      |-> UP_DATA_OUT == TX_CLOCK_OFF) else $error("tx clock status wrong");
   AST_PLL_STATUS: assert property ((rd_on && UP_ADDR == 10'h09D) [*4] |->
      UP_DATA_OUT == {6'h00, PLL_REFERENCE_ONE_OFF, PLL_REFERENCE_ZERO_OFF})
      else $error("pll status wrong");
   AST_IE_CAUSE: assert property ($changed(CNT_IRQ_ENABLE) |->
      $past(!UP_CS_N && !UP_WR_N && UP_ADDR == 10'h207, 4)) else $error("enable moved alone");
   AST_UNMAPPED: assert property ((rd_on && UP_ADDR == 10'h3FF)[*4] |-> UP_DATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   cover property (rd_on && UP_ADDR == 10'h214 && UP_DATA_OE);
   cover property ($rose(CNT_IRQ_ENABLE != '0));
   cover property (rd_on && UP_ADDR == 10'h207 && UP_DATA_OUT[7]);
endmodule
bind scar_regs scar_regs_monitor scar_regs_monitor_inst (.CLK_SYS(CLK_SYS), .NRST(NRST),
   .UP_CS_N(UP_CS_N), .UP_RD_N(UP_RD_N), .UP_WR_N(UP_WR_N), .UP_ADDR(UP_ADDR),
   .UP_DATA_OUT(UP_DATA_OUT), .UP_DATA_OE(UP_DATA_OE), .TX_CLOCK_OFF(TX_CLOCK_OFF),
   .PLL_REFERENCE_ZERO_OFF(PLL_REFERENCE_ZERO_OFF),
   .PLL_REFERENCE_ONE_OFF(PLL_REFERENCE_ONE_OFF), .CNT_IRQ_ENABLE(CNT_IRQ_ENABLE));

// *** bench/scar_regs_tb.sv ***
// self-checking bench for the stats counter access register bank
`timescale 1ns/1ps
module scar_regs_tb;
   import scar_pkg::*;
   logic               clk_sys = 0;
   logic               nrst = 0;
   logic               cs_n = 1;
   logic               rd_n = 1;
   logic               wr_n = 1;
   logic [9:0]         addr = '0;
   logic [7:0]         din = '0;
   logic [7:0]         txoff = '0;
   logic               p0 = 0;
   logic               p1 = 0;
   logic [CNT_NUM-1:0] ev = '0;
   logic [CNT_NUM-1:0] ie;
   logic [7:0]         dout;
   logic               oe;
   logic [7:0]         v;
   int                 mdl [CNT_NUM];
   int                 miscompares = 0;
   int                 cmp_count = 0;
   int                 slot;
   scar_regs scar_regs_inst (.CLK_SYS(clk_sys), .NRST(nrst), .UP_CS_N(cs_n), .UP_RD_N(rd_n),
      .UP_WR_N(wr_n), .UP_ADDR(addr), .UP_DATA_IN(din), .UP_DATA_OUT(dout), .UP_DATA_OE(oe),
      .TX_CLOCK_OFF(txoff), .PLL_REFERENCE_ZERO_OFF(p0), .PLL_REFERENCE_ONE_OFF(p1),
      .CNT_EVENT(ev), .CNT_IRQ_ENABLE(ie));
   initial forever #2 clk_sys = ~clk_sys;
   // ****************************************************************
   // bus tasks and model compare
   // ****************************************************************
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic [9:0] a, input logic [7:0] d, input logic w, input int n);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      rd_n <= w;
      wr_n <= !w;
      addr <= a;
      din <= d;
      repeat (n) @(posedge clk_sys);
      v = dout;
      if (!w) check(oe, 1'b1);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [9:0] a);
      acc(a, 8'h00, 1'b0, 4);
   endtask
   task automatic xfer(input logic [7:0] c);
      acc(ADDR_TRANSFER_COMMAND, c, 1'b1, 5);
      v = 8'h00;
      for (int n = 0; n < 8 && v[7] !== 1'b1; n++) rd(ADDR_TRANSFER_COMMAND);
      check(v[7], 1'b1);
      if (v[7] !== 1'b1) results();
   endtask
   task automatic rdcnt(input logic [7:0] s, input int k);
      logic [23:0] e;
      e = (k < 0) ? 24'h0 : 24'(mdl[k]);
      acc(ADDR_COUNTER_TARGET_SELECT, s, 1'b1, 5);
      xfer(8'h05);
      rd(ADDR_COUNTER_BYTE_HIGH);
      check(v, e[23:16]);
      rd(ADDR_COUNTER_BYTE_MIDDLE);
      check(v, e[15:8]);
      rd(ADDR_COUNTER_BYTE_LOW);
      check(v, e[7:0]);
   endtask
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         ev[k] <= 1'b1;
         @(posedge clk_sys);
         ev[k] <= 1'b0;
      end
   endtask
   task automatic wbytes(input logic [23:0] b);
      acc(ADDR_COUNTER_BYTE_HIGH, b[23:16], 1'b1, 5);
      acc(ADDR_COUNTER_BYTE_MIDDLE, b[15:8], 1'b1, 5);
      acc(ADDR_COUNTER_BYTE_LOW, b[7:0], 1'b1, 5);
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(11));
      mdl = '{default: 0};
      @(posedge clk_sys);
      txoff <= 8'($urandom);
      p0 <= 1'($urandom);
      p1 <= 1'($urandom);
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int a = 10'h214; a < 10'h218; a++) begin
         rd(10'(a));
         check(v, 8'h00);
      end
      rd(ADDR_TX_CLOCK_OFF_STATUS);
      check(v, txoff);
      rd(ADDR_PLL_REF_CLOCK_OFF_STATUS);
      check(v, {6'h00, p1, p0});
      rd(10'h3FF);
      check(v, 8'h00);
      $display("test reset and status done");
      for (int t = 0; t < 12; t++) begin
         int lk;
         lk = (t > 7) ? 8 + $urandom % 4 : $urandom % 8;
         slot = (t > 7) ? t * 8 + lk - 8 : t * 8 + lk;
         pulse(slot, 1 + t);
         if (t != 4) mdl[slot] += 1 + t;
         rdcnt({4'(t), 4'(lk)}, (t == 4) ? -1 : slot);
      end
      $display("test counter types done");
      wbytes(24'($urandom));
      rdcnt(8'h35, 29);
      wbytes(24'hFFFFFF);
      xfer(8'h01);
      mdl[29] = 24'hFFFFFF + 2;
      pulse(29, 2);
      rdcnt(8'h35, 29);
      $display("test preload done");
      acc(ADDR_COUNTER_TARGET_SELECT, 8'hB9, 1'b1, 5);
      xfer(8'h0A);
      check(ie, 128'(1) << 89);
      xfer(8'h02);
      check(ie, 128'h0);
      xfer(8'h0A);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      mdl = '{default: 0};
      check(ie, 128'h0);
      rdcnt(8'h35, 29);
      $display("test enable and reset done");
      results();
   end
endmodule
